/* pkg/serial_tx_pkg.sv */
package serial_tx_pkg;

   // Clock and timing figures
   localparam int CLK_FREQ_KHZ = 100000;
   localparam int STANDBY_FREQ_KHZ = 500;
   localparam int ACTIVE_FREQ_KHZ = 3000;
   localparam int ENABLE_FILTER_US = 10;
   localparam int LOCK_TIMEOUT_MS = 2;
   // Slowest period still seen as live clock, rounded down
   localparam int STANDBY_PERIOD_CYC = CLK_FREQ_KHZ / STANDBY_FREQ_KHZ;
   // Period at or under which the clock counts as active, rounded down
   localparam int ACTIVE_PERIOD_CYC = CLK_FREQ_KHZ / ACTIVE_FREQ_KHZ;
   localparam int ENABLE_FILTER_CYC = ENABLE_FILTER_US * (CLK_FREQ_KHZ / 1000);
   localparam int LOCK_TIMEOUT_CYC = LOCK_TIMEOUT_MS * CLK_FREQ_KHZ;

   // Frame geometry, serial order is bit 0 first
   localparam int FRAME_BITS = 30;
   localparam int PAYLOAD_BITS = 27;
   localparam int PIXEL_BITS = 24;
   localparam int FRM_PIXEL_LSB = 0;
   localparam int FRM_VSYNC_POS = 24;
   localparam int FRM_HSYNC_POS = 25;
   localparam int FRM_VALID_POS = 26;
   localparam int FRM_PARITY_POS = 27;
   localparam int FRM_RSVD0_POS = 28;
   localparam int FRM_RSVD1_POS = 29;
   localparam logic FRM_RSVD_VALUE = 1'h0;
   localparam logic [4:0] PHASE_LAST = 5'h1D;
   localparam logic [4:0] PHASE_HALF = 5'h0F;
   localparam logic [4:0] PHASE_ZERO = 5'h00;

   // Lock monitor: consecutive periods of exactly one frame before lock
   localparam logic [2:0] LOCK_PERIODS = 3'h4;

   localparam logic [7:0] PERIOD_SAT = 8'(STANDBY_PERIOD_CYC);
   localparam logic [7:0] PERIOD_ACTIVE = 8'(ACTIVE_PERIOD_CYC);
   localparam logic [7:0] PERIOD_FRAME = 8'(FRAME_BITS - 1);
   localparam logic [9:0] FILTER_LAST = 10'(ENABLE_FILTER_CYC - 1);

   typedef enum logic [2:0]
   {
      MODE_SHUTDOWN = 3'b000,
      MODE_STANDBY = 3'b001,
      MODE_ACQUIRE = 3'b010,
      MODE_TRANSMIT = 3'b011,
      MODE_CLK_OFF = 3'b100
   } tx_mode_t;

   typedef struct packed
   {
      logic pixel_valid;
      logic horizontal_sync;
      logic vertical_sync;
      logic [PIXEL_BITS-1:0] pixels;
   } pixel_word_t;

   typedef struct packed
   {
      logic p;
      logic n;
      logic oe;
   } diff_pair_t;

endpackage : serial_tx_pkg

/* hw/display_serial_transmitter.sv */
// Functional notes
// - Shift frame out at thirty times pixel clock
// - Frame: 27 payload, parity, two reserved bits
// - Link clock is shift clock divided by thirty
// - Pixel clock 4 to 15 MHz; PLL locks there (the lock monitor here locks only at a 30-cycle period)
// - Enable low: shutdown, everything off, outputs Z
// - Slow pixel clock: standby, PLL off, Z
// - Pixel clock above 3 MHz starts active sequence
// - Acquire: PLL on, Z until lock seen
// - Parity covers payload, not reserved bits
// - Parity set on even ones count
// - Enable high over 10 us enters standby
// - Standby plus activity enters acquire, outputs Z
// - Lock within 2 ms, load, clock, data (here clock and data pairs start in one cycle)
// - Missing pixel clock returns to standby
// - Enable low over 10 us: clock, then data off
// - Shutdown keeps inputs sampled, switching logic off
// - Edge select: 0 rising, 1 falling capture
// - Bus order: 0 blue-first, 1 red-first
// - Power-up takes enable level without filter
`timescale 1ns/100ps

module display_serial_transmitter
   import serial_tx_pkg::*;
#(
   parameter int LOCK_TIMEOUT = LOCK_TIMEOUT_CYC
)
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic clk_en_in,
   input wire logic pixel_clock_in,
   input wire pixel_word_t pixel_bus_in,
   input wire logic capture_edge_select_in,
   input wire logic bus_order_in,
   input wire logic transmit_enable_pin_in,
   output diff_pair_t data_pair_out,
   output diff_pair_t clock_pair_out,
   output tx_mode_t mode_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Input stage, enable filter and activity monitor

   logic pclk_prev_r;
   logic pclk_prev_nxt;
   logic [7:0] period_r;
   logic [7:0] period_nxt;
   logic active_r;
   logic active_nxt;
   logic enable_r;
   logic enable_nxt;
   logic init_done_r;
   logic init_done_nxt;
   logic [9:0] filter_cnt_r;
   logic [9:0] filter_cnt_nxt;
   logic [2:0] lock_cnt_r;
   logic [2:0] lock_cnt_nxt;
   pixel_word_t hold_r;
   pixel_word_t hold_nxt;
   pixel_word_t ordered;
   logic rise_edge;
   logic fall_edge;
   logic capture_edge;
   tx_mode_t mode_r;
   tx_mode_t mode_nxt;

   // Red-first order is the mirror image of the pixel pins
   always_comb
   begin
      ordered = pixel_bus_in;
      for (int i = 0; i < PIXEL_BITS; i++)
      begin
         ordered.pixels[i] = bus_order_in ? pixel_bus_in.pixels[PIXEL_BITS-1-i] :
                             pixel_bus_in.pixels[i];
      end
   end

   assign rise_edge = pixel_clock_in & ~pclk_prev_r;
   assign fall_edge = ~pixel_clock_in & pclk_prev_r;
   assign capture_edge = capture_edge_select_in ? fall_edge : rise_edge;

   always_comb
   begin
      pclk_prev_nxt = pixel_clock_in;
      period_nxt = period_r;
      active_nxt = active_r;
      enable_nxt = enable_r;
      init_done_nxt = 1'h1;
      filter_cnt_nxt = 10'h000;
      lock_cnt_nxt = lock_cnt_r;
      hold_nxt = hold_r;
      // Monitor: saturating period counter, judged at each rising edge
      if (rise_edge)
      begin
         period_nxt = 8'h00;
         if (period_r < PERIOD_ACTIVE)
         begin
            active_nxt = 1'h1;
         end
      end
      // Saturates instead of wrapping, so a stopped clock never looks fast
      else if (period_r != PERIOD_SAT)
      begin
         period_nxt = period_r + 8'h01;
      end
      else
      begin
         active_nxt = 1'h0;
      end
      // Between the two thresholds the last verdict is kept

      // Glitch filter; first cycle after reset trusts the pin directly
      // A bounce restarts the count, so short spikes never reach the modes
      if (!init_done_r)
      begin
         enable_nxt = transmit_enable_pin_in;
      end
      else if (transmit_enable_pin_in != enable_r)
      begin
         if (filter_cnt_r == FILTER_LAST)
         begin
            enable_nxt = transmit_enable_pin_in;
         end
         else
         begin
            filter_cnt_nxt = filter_cnt_r + 10'h001;
         end
      end

      // Lock monitor: the shift clock matches when a period is one frame
      // Any other period restarts it, so a clock in the unlockable band stays out
      if (mode_r != MODE_ACQUIRE)
      begin
         lock_cnt_nxt = 3'h0;
      end
      else if (rise_edge)
      begin
         if (period_r == PERIOD_FRAME)
         begin
            if (lock_cnt_r != LOCK_PERIODS)
            begin
               lock_cnt_nxt = lock_cnt_r + 3'h1;
            end
         end
         else
         begin
            lock_cnt_nxt = 3'h0;
         end
      end

      // Acquire captures too, so the first frame sent carries live data
      if (capture_edge && (mode_r == MODE_ACQUIRE || mode_r == MODE_TRANSMIT))
      begin
         hold_nxt = ordered;
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         pclk_prev_r <= 1'h0;
         period_r <= PERIOD_SAT;
         active_r <= 1'h0;
         enable_r <= 1'h0;
         init_done_r <= 1'h0;
         filter_cnt_r <= 10'h000;
         lock_cnt_r <= 3'h0;
         hold_r <= '0;
      end
      else if (clk_en_in)
      begin
         pclk_prev_r <= pclk_prev_nxt;
         period_r <= period_nxt;
         active_r <= active_nxt;
         enable_r <= enable_nxt;
         init_done_r <= init_done_nxt;
         filter_cnt_r <= filter_cnt_nxt;
         lock_cnt_r <= lock_cnt_nxt;
         hold_r <= hold_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode machine, serializer and output pairs

   logic [17:0] timeout_r;
   logic [17:0] timeout_nxt;
   logic [4:0] phase_r;
   logic [4:0] phase_nxt;
   logic [FRAME_BITS-1:0] shift_r;
   logic [FRAME_BITS-1:0] shift_nxt;
   logic [FRAME_BITS-1:0] frame;
   diff_pair_t data_pair_r;
   diff_pair_t data_pair_nxt;
   diff_pair_t clock_pair_r;
   diff_pair_t clock_pair_nxt;
   logic link_clk;
   logic locked;

   assign locked = (lock_cnt_r == LOCK_PERIODS);

   // Frame assembly; reserved bits stay out of the parity
   always_comb
   begin
      frame = '0;
      frame[FRM_PIXEL_LSB +: PIXEL_BITS] = hold_r.pixels;
      frame[FRM_VSYNC_POS] = hold_r.vertical_sync;
      frame[FRM_HSYNC_POS] = hold_r.horizontal_sync;
      frame[FRM_VALID_POS] = hold_r.pixel_valid;
      // The held word is exactly the payload, so parity folds all of it
      frame[FRM_PARITY_POS] = ~(^hold_r);
      frame[FRM_RSVD0_POS] = FRM_RSVD_VALUE;
      frame[FRM_RSVD1_POS] = FRM_RSVD_VALUE;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next mode, shift register and pair values

   always_comb
   begin
      mode_nxt = mode_r;
      timeout_nxt = 18'h00000;
      phase_nxt = PHASE_ZERO;
      shift_nxt = shift_r;
      link_clk = 1'h0;
      unique case (mode_r)
         MODE_SHUTDOWN:
         begin
            // Serializer held cleared; only the input samplers keep running
            shift_nxt = '0;
            if (enable_r)
            begin
               mode_nxt = MODE_STANDBY;
            end
         end
         MODE_STANDBY:
         begin
            if (!enable_r)
            begin
               mode_nxt = MODE_SHUTDOWN;
            end
            else if (active_r)
            begin
               mode_nxt = MODE_ACQUIRE;
            end
         end
         MODE_ACQUIRE:
         begin
            timeout_nxt = timeout_r + 18'h00001;
            // Phase follows the pixel clock until lock
            phase_nxt = rise_edge ? PHASE_ZERO : phase_r + 5'h01;
            if (!enable_r)
            begin
               mode_nxt = MODE_SHUTDOWN;
            end
            // No lock inside the window: fall back and let the monitor retry
            else if (!active_r || timeout_r == 18'(LOCK_TIMEOUT - 1))
            begin
               mode_nxt = MODE_STANDBY;
            end
            else if (locked && rise_edge)
            begin
               mode_nxt = MODE_TRANSMIT;
               shift_nxt = frame;
            end
         end
         MODE_TRANSMIT:
         begin
            // Free running phase stands in for the locked PLL
            phase_nxt = (phase_r == PHASE_LAST) ? PHASE_ZERO : phase_r + 5'h01;
            if (phase_r == PHASE_LAST)
            begin
               shift_nxt = frame;
            end
            else
            begin
               shift_nxt = {1'h0, shift_r[FRAME_BITS-1:1]};
            end
            if (!enable_r)
            begin
               mode_nxt = MODE_CLK_OFF;
            end
            else if (!active_r)
            begin
               mode_nxt = MODE_STANDBY;
            end
         end
         MODE_CLK_OFF:
         begin
            // Data stays driven one more cycle so the clock pair lets go first
            mode_nxt = MODE_SHUTDOWN;
         end
         default:
         begin
            // Unused codes recover through shutdown
            mode_nxt = MODE_SHUTDOWN;
         end
      endcase
      // From the next phase, so the clock rises with bit 0, on entry as well
      link_clk = (phase_nxt <= PHASE_HALF);
      // Clock pair driven only in transmit, data pair in clock-off too; both start in one cycle
      clock_pair_nxt.oe = (mode_nxt == MODE_TRANSMIT);
      clock_pair_nxt.p = clock_pair_nxt.oe & link_clk;
      clock_pair_nxt.n = clock_pair_nxt.oe & ~link_clk;
      data_pair_nxt.oe = (mode_nxt == MODE_TRANSMIT) || (mode_nxt == MODE_CLK_OFF);
      data_pair_nxt.p = data_pair_nxt.oe & shift_nxt[0];
      data_pair_nxt.n = data_pair_nxt.oe & ~shift_nxt[0];
   end

   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         mode_r <= MODE_SHUTDOWN;
         timeout_r <= 18'h00000;
         phase_r <= PHASE_ZERO;
         shift_r <= '0;
         data_pair_r <= '0;
         clock_pair_r <= '0;
      end
      else if (clk_en_in)
      begin
         mode_r <= mode_nxt;
         timeout_r <= timeout_nxt;
         phase_r <= phase_nxt;
         shift_r <= shift_nxt;
         data_pair_r <= data_pair_nxt;
         clock_pair_r <= clock_pair_nxt;
      end
   end

   assign data_pair_out = data_pair_r;
   assign clock_pair_out = clock_pair_r;
   assign mode_out = mode_r;

endmodule : display_serial_transmitter

/* testbench/display_serial_transmitter_properties.sv */
`timescale 1ns/100ps

module serial_tx_checker
   import serial_tx_pkg::*;
#(
   parameter int LOCK_TIMEOUT = LOCK_TIMEOUT_CYC
)
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire diff_pair_t data_pair_out,
   input wire diff_pair_t clock_pair_out,
   input wire tx_mode_t mode_out
);
   logic tx;
   int acq_cycles;

   assign tx = mode_out == MODE_TRANSMIT;

   // Consecutive acquire cycles, to bound the lock window
   always_ff @(posedge clk_in or posedge sys_rst_in)
   begin
      if (sys_rst_in)
      begin
         acq_cycles <= 0;
      end
      else
      begin
         acq_cycles <= (mode_out == MODE_ACQUIRE) ? acq_cycles + 1 : 0;
      end
   end

   default clocking @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);

   sequence s_tx_rise;
      $rose(clock_pair_out.p) && tx;
   endsequence

   sequence s_off_step;
      !clock_pair_out.oe && data_pair_out.oe ##1 mode_out == MODE_SHUTDOWN && !data_pair_out.oe;
   endsequence

   ////////////////////////////////////////
   property p_data_oe;
      data_pair_out.oe |-> mode_out inside {MODE_TRANSMIT, MODE_CLK_OFF};
   endproperty
   a_data_oe: assert property (p_data_oe) else $error("data pair on off mode");

   property p_clk_oe;
      clock_pair_out.oe == tx;
   endproperty
   a_clk_oe: assert property (p_clk_oe) else $error("clock pair enable wrong");

   property p_off;
      mode_out == MODE_CLK_OFF |-> s_off_step;
   endproperty
   a_off: assert property (p_off) else $error("shutdown order wrong");

   property p_quiet;
      !tx && mode_out != MODE_CLK_OFF |-> data_pair_out == '0 && clock_pair_out == '0;
   endproperty
   a_quiet: assert property (p_quiet) else $error("pairs not idle");

   property p_acq;
      mode_out == MODE_STANDBY ##1 mode_out != MODE_STANDBY |-> mode_out inside {MODE_ACQUIRE, MODE_SHUTDOWN};
   endproperty
   a_acq: assert property (p_acq) else $error("standby exit wrong");

   property p_tx_in;
      !tx ##1 tx |-> $past(mode_out) == MODE_ACQUIRE && clock_pair_out.p && data_pair_out.oe;
   endproperty
   a_tx_in: assert property (p_tx_in) else $error("transmit entry wrong");

   property p_wave;
      s_tx_rise |-> ##15 (clock_pair_out.p || !tx) ##1 (!clock_pair_out.p || !tx) ##14 (clock_pair_out.p || !tx);
   endproperty
   a_wave: assert property (p_wave) else $error("link clock period wrong");

   property p_rsvd;
      s_tx_rise |-> ##28 (!data_pair_out.p || !tx) [*2];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

   property p_diff;
      (!data_pair_out.oe || data_pair_out.p != data_pair_out.n) &&
      (!clock_pair_out.oe || clock_pair_out.p != clock_pair_out.n);
   endproperty
   a_diff: assert property (p_diff) else $error("driven pair not complementary");

   property p_lock_window;
      acq_cycles < LOCK_TIMEOUT;
   endproperty
   a_lock_window: assert property (p_lock_window) else $error("acquire past lock window");
endmodule : serial_tx_checker

bind display_serial_transmitter serial_tx_checker #(.LOCK_TIMEOUT(LOCK_TIMEOUT)) serial_tx_checker_inst
(
   .clk_in(clk_in),
   .sys_rst_in(sys_rst_in),
   .data_pair_out(data_pair_out),
   .clock_pair_out(clock_pair_out),
   .mode_out(mode_out)
);

/* testbench/pixel_host_model.sv */
`timescale 1ns/100ps

module pixel_host_model
   import serial_tx_pkg::*;
(
   input wire logic clk_in,
   input wire logic run_in,
   input wire pixel_word_t word_in,
   output logic pixel_clock_out,
   output pixel_word_t pixel_bus_out
);
   logic [4:0] phase_r = 5'h00;

   initial {pixel_clock_out, pixel_bus_out} = '0;

   // Fixed 30-cycle period, clear of the unlockable band; low while stopped
   always @(negedge clk_in)
   begin
      if (run_in)
         phase_r <= (phase_r == 5'h1D) ? 5'h00 : phase_r + 5'h01;
      pixel_clock_out <= run_in && phase_r < 5'h0F;
      // Inverse word near rising edge, so a wrong capture edge shows
      if (phase_r == 5'h07)
         pixel_bus_out <= word_in;
      if (phase_r == 5'h16)
         pixel_bus_out <= ~word_in;
   end
endmodule : pixel_host_model

/* testbench/display_serial_transmitter_bench.sv */
`timescale 1ns/100ps

module display_serial_transmitter_bench;
   import serial_tx_pkg::*;

   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic run = 1'b0;
   logic edge_sel = 1'b0;
   logic order = 1'b0;
   logic enable = 1'b1;
   logic pclk;
   logic [29:0] frame;
   pixel_word_t word = '0;
   pixel_word_t bus;
   diff_pair_t data_pair;
   diff_pair_t clock_pair;
   tx_mode_t mode;
   int error_cnt = 0;
   int compares = 0;
   int n;
   pixel_word_t words [4] = '{27'h0000000, 27'h4000001, 27'h7FFFFFF, 27'h2A5C3E1};

   always #5 clk_in = ~clk_in;

   pixel_host_model pixel_host_model_inst
   (
      .clk_in(clk_in),
      .run_in(run),
      .word_in(word),
      .pixel_clock_out(pclk),
      .pixel_bus_out(bus)
   );

   display_serial_transmitter #(.LOCK_TIMEOUT(2000)) display_serial_transmitter_inst
   (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .clk_en_in(1'b1),
      .pixel_clock_in(pclk),
      .pixel_bus_in(bus),
      .capture_edge_select_in(edge_sel),
      .bus_order_in(order),
      .transmit_enable_pin_in(enable),
      .data_pair_out(data_pair),
      .clock_pair_out(clock_pair),
      .mode_out(mode)
   );

   ////////////////////////////////////////
   task automatic wrap_up;
      if (error_cnt == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : wrap_up

   task automatic check(input logic [29:0] got, input logic [29:0] exp);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic check_mode(input tx_mode_t exp);
      check(30'(mode), 30'(exp));
   endtask : check_mode

   task automatic wait_mode(input tx_mode_t m, input int limit);
      n = 0;
      while (mode !== m)
      begin
         @(negedge clk_in);
         n++;
         if (n > limit)
         begin
            error_cnt++;
            wrap_up();
         end
      end
   endtask : wait_mode

   // Frame starts where the link clock rises
   task automatic grab_frame;
      int i;
      logic last;
      last = 1'b1;
      for (i = 0; i < 60 && !(last === 1'b0 && clock_pair.p === 1'b1); i++)
      begin
         last = clock_pair.p;
         @(negedge clk_in);
      end
      if (i == 60)
      begin
         error_cnt++;
         wrap_up();
      end
      for (i = 0; i < 30; i++)
      begin
         frame[i] = data_pair.p;
         @(negedge clk_in);
      end
   endtask : grab_frame

   function automatic logic [29:0] expect_frame(input pixel_word_t w);
      logic [23:0] px;
      px = w.pixels;
      if (order)
         px = {<<{w.pixels}};
      return {2'h0, ~^{w[26:24], px}, w[26:24], px};
   endfunction : expect_frame

   ////////////////////////////////////////
   initial
   begin
      repeat (16) @(negedge clk_in);
      sys_rst_in = 1'b0;
      run <= 1'b1;
      wait_mode(MODE_STANDBY, 8);
      wait_mode(MODE_TRANSMIT, 400);
      for (int k = 0; k < 4; k++)
      begin
         word <= words[k];
         order = k[0];
         edge_sel = k[1];
         repeat (150) @(negedge clk_in);
         grab_frame();
         check(frame, expect_frame(edge_sel ? word : ~word));
      end
      run <= 1'b0;
      wait_mode(MODE_STANDBY, 400);
      check(30'(data_pair), 30'h0);
      run <= 1'b1;
      wait_mode(MODE_ACQUIRE, 100);
      wait_mode(MODE_TRANSMIT, 400);
      enable = 1'b0;
      repeat (500) @(negedge clk_in);
      enable = 1'b1;
      repeat (600) @(negedge clk_in);
      check_mode(MODE_TRANSMIT);
      enable = 1'b0;
      wait_mode(MODE_CLK_OFF, 1100);
      check(30'(n > 990), 30'h1);
      check(30'({data_pair.oe, clock_pair.oe}), 30'h2);
      @(negedge clk_in);
      check_mode(MODE_SHUTDOWN);
      enable = 1'b1;
      wait_mode(MODE_STANDBY, 1100);
      check(30'(n > 990), 30'h1);
      wait_mode(MODE_TRANSMIT, 400);
      wrap_up();
   end
endmodule : display_serial_transmitter_bench
